// ===== rtl/pcec_pkg.sv
/*
 * Constants for the pulse capture and event counter block: register
 * indices, field positions, mode codes, states and clock divider figures.
 * Assumes a single 10 MHz system clock and an AXI4-Lite register bus.
 */
package pcec_pkg;

   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [7:0] IDX_TIMER_MODE = 8'ha0;
   localparam logic [7:0] IDX_TIMER_LOW  = 8'ha1;
   localparam logic [7:0] IDX_TIMER_HIGH = 8'ha2;
   localparam logic [7:0] IDX_EVENT_LOW  = 8'ha3;
   localparam logic [7:0] IDX_EVENT_HIGH = 8'ha4;
   localparam logic [7:0] IDX_CAPT_CTRL  = 8'ha5;
   localparam logic [7:0] IDX_STATUS     = 8'ha6;
   localparam int         ADDR_W         = 12;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int TM_ENABLE   = 7;
   localparam int TM_RATE_HI  = 6;
   localparam int TM_RATE_LO  = 4;
   localparam int TM_CLK_SEL  = 3;
   localparam int CC_EVT_EN   = 7;
   localparam int CC_IN_SEL   = 3;
   localparam int CC_START    = 2;
   localparam int CC_FSEL_HI  = 1;
   localparam int CC_FSEL_LO  = 0;
   localparam int ST_IRQ      = 0;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ****************************************************************
   // Function select codes, counter limits, bus answers
   // ****************************************************************
   localparam logic [1:0] FS_OFF   = 2'h0;
   localparam logic [1:0] FS_HIGH  = 2'h1;
   localparam logic [1:0] FS_LOW   = 2'h2;
   localparam logic [1:0] FS_CYCLE = 2'h3;
   localparam logic [9:0] EVENT_MAX = 10'h3ff;
   localparam logic [6:0] PRE_FULL  = 7'h7f;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ****************************************************************
   // Timing: instruction clock is the system clock divided by four
   // ****************************************************************
   localparam int         SYS_CLK_HZ = 10000000;
   localparam int         CPU_CLK_HZ = 2500000;
   localparam logic [1:0] CPU_DIV_M1 = 2'(SYS_CLK_HZ / CPU_CLK_HZ - 1);

   typedef enum logic [1:0] {
      PCEC_IDLE = 2'b00,
      PCEC_WAIT = 2'b01,
      PCEC_RUN  = 2'b10
   } pcec_state_t;

endpackage

// ===== rtl/pcec_capture.sv
/*
 * Pulse capture unit with 10-bit event counter and its 16-bit timer count,
 * behind an AXI4-Lite slave. Assumes inputs synchronous to sys_clk_i and
 * a master that keeps at most one read and one write outstanding.
 */
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module pcec_capture (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        capture_input_pin_i,
   input  wire logic                        resistor_freq_osc_i,
   input  wire logic [pcec_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic                        s_axi_awvalid_i,
   output logic                             s_axi_awready_o,
   input  wire logic [31:0]                 s_axi_wdata_i,
   input  wire logic [3:0]                  s_axi_wstrb_i,
   input  wire logic                        s_axi_wvalid_i,
   output logic                             s_axi_wready_o,
   output logic [1:0]                       s_axi_bresp_o,
   output logic                             s_axi_bvalid_o,
   input  wire logic                        s_axi_bready_i,
   input  wire logic [pcec_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic                        s_axi_arvalid_i,
   output logic                             s_axi_arready_o,
   output logic [31:0]                      s_axi_rdata_o,
   output logic [1:0]                       s_axi_rresp_o,
   output logic                             s_axi_rvalid_o,
   input  wire logic                        s_axi_rready_i,
   output logic                             timer_irq_flag_o
);
   import pcec_pkg::*;

   pcec_state_t state, next_state;
   logic       timer_enable, next_timer_enable, timer_clock_select, next_timer_clock_select;
   logic [2:0] timer_prescale, next_timer_prescale;
   logic       event_count_enable, next_event_count_enable;
   logic       capture_input_select, next_capture_input_select;
   logic       capture_start, next_capture_start, irq, next_irq;
   logic [1:0] capture_function_select, next_capture_function_select;
   logic [15:0] tcnt, next_tcnt, tsnap, next_tsnap;
   logic [7:0]  thold, next_thold;
   logic [9:0]  ecnt, next_ecnt, esnap, next_esnap;
   logic [1:0]  ehold, next_ehold, cpu_cnt, next_cpu_cnt;
   logic [6:0]  pre, next_pre;
   logic        sync1, sync2, samp, next_samp;
   logic        awready, next_awready, bvalid, next_bvalid, arready, next_arready;
   logic        rvalid, next_rvalid;
   logic [1:0]  bresp, next_bresp, rresp, next_rresp;
   logic [7:0]  rdata, next_rdata, rd_byte;
   logic        cpu_tick, tick, rise, fall, active, start_edge, stop_edge, ovf;
   logic        wr, rd, wmap, rmap, wlo;
   logic [7:0]  widx, ridx, wbyte;
   logic [6:0]  mask;

   // ****************************************************************
   // Timer tick and input edges
   // ****************************************************************
   assign cpu_tick = (cpu_cnt == CPU_DIV_M1);
   assign mask     = PRE_FULL >> timer_prescale;
   // Fast clock is the system clock itself, so every cycle ticks
   assign tick     = timer_clock_select | (cpu_tick & ((pre | ~mask) == PRE_FULL));
   assign rise     = tick & sync2 & ~samp;
   assign fall     = tick & ~sync2 & samp;
   assign active   = timer_enable & capture_start & (capture_function_select != FS_OFF);

   // Edges that open and close a measurement; a level already present never counts
   always_comb begin
      start_edge = rise;
      stop_edge  = rise;
      if (!event_count_enable && capture_function_select == FS_LOW) begin
         start_edge = fall;
      end
      if (capture_function_select == FS_HIGH) begin
         stop_edge = fall;
      end
   end
   assign ovf = event_count_enable & rise & (ecnt == EVENT_MAX);

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   assign wr    = s_axi_awvalid_i & awready & s_axi_wvalid_i;
   assign rd    = s_axi_arvalid_i & arready;
   assign widx  = s_axi_awaddr_i[9:2];
   assign ridx  = s_axi_araddr_i[9:2];
   assign wmap  = (s_axi_awaddr_i[11:10] == 2'h0) && widx >= IDX_TIMER_MODE && widx <= IDX_STATUS;
   assign rmap  = (s_axi_araddr_i[11:10] == 2'h0) && ridx >= IDX_TIMER_MODE && ridx <= IDX_STATUS;
   assign wlo   = wr & wmap & s_axi_wstrb_i[0];
   assign wbyte = s_axi_wdata_i[7:0];

   always_comb begin
      case (ridx)
         IDX_TIMER_MODE: rd_byte = {timer_enable, timer_prescale, timer_clock_select, 3'h0};
         IDX_TIMER_LOW:  rd_byte = tcnt[7:0];
         IDX_TIMER_HIGH: rd_byte = tsnap[15:8];
         IDX_EVENT_LOW:  rd_byte = ecnt[7:0];
         IDX_EVENT_HIGH: rd_byte = {6'h0, esnap[9:8]};
         IDX_CAPT_CTRL:  rd_byte = {event_count_enable, 3'h0, capture_input_select,
                                    capture_start, capture_function_select};
         IDX_STATUS:     rd_byte = {7'h0, irq};
         default:        rd_byte = RESET_BYTE;
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      next_state = state;
      next_timer_enable = timer_enable;
      next_timer_prescale = timer_prescale;
      next_timer_clock_select = timer_clock_select;
      next_event_count_enable = event_count_enable;
      next_capture_input_select = capture_input_select;
      next_capture_start = capture_start;
      next_capture_function_select = capture_function_select;
      next_irq = irq;
      next_tcnt = tcnt;
      next_tsnap = tsnap;
      next_thold = thold;
      next_ecnt = ecnt;
      next_esnap = esnap;
      next_ehold = ehold;
      next_cpu_cnt = cpu_tick ? 2'h0 : cpu_cnt + 2'h1;
      next_pre = cpu_tick ? pre + 7'h1 : pre;
      next_samp = tick ? sync2 : samp;
      next_awready = s_axi_awvalid_i & s_axi_wvalid_i & ~awready & ~bvalid;
      next_bvalid = bvalid & ~s_axi_bready_i;
      next_bresp = bresp;
      next_arready = s_axi_arvalid_i & ~arready & ~rvalid;
      next_rvalid = rvalid & ~s_axi_rready_i;
      next_rresp = rresp;
      next_rdata = rdata;

      // Software clear goes first so a same-cycle hardware set wins
      if (wlo && widx == IDX_STATUS && wbyte[ST_IRQ]) begin
         next_irq = 1'b0;
      end

      case (state)
         PCEC_IDLE: begin
            if (active) begin
               next_state = PCEC_WAIT;
            end
         end
         PCEC_WAIT: begin
            if (!active) begin
               next_state = PCEC_IDLE;
            end else if (start_edge) begin
               next_state = PCEC_RUN;
            end
         end
         PCEC_RUN: begin
            if (!active) begin
               next_state = PCEC_IDLE;
            end else if (event_count_enable ? ovf : stop_edge) begin
               next_state = PCEC_IDLE;
               next_capture_start = 1'b0;
               next_irq = 1'b1;
               if (ovf) begin
                  next_ecnt = 10'h0;
               end
            end else begin
               if (tick) begin
                  next_tcnt = tcnt + 16'h1;
               end
               if (event_count_enable && rise) begin
                  next_ecnt = ecnt + 10'h1;
               end
            end
         end
         default: next_state = PCEC_IDLE;
      endcase

      if (wlo) begin
         case (widx)
            IDX_TIMER_MODE: begin
               next_timer_enable = wbyte[TM_ENABLE];
               next_timer_prescale = wbyte[TM_RATE_HI:TM_RATE_LO];
               next_timer_clock_select = wbyte[TM_CLK_SEL];
            end
            IDX_TIMER_HIGH: next_thold = wbyte;
            IDX_TIMER_LOW:  next_tcnt = {thold, wbyte};
            IDX_EVENT_HIGH: next_ehold = wbyte[1:0];
            IDX_EVENT_LOW:  next_ecnt = {ehold, wbyte};
            IDX_CAPT_CTRL: begin
               next_event_count_enable = wbyte[CC_EVT_EN];
               next_capture_input_select = wbyte[CC_IN_SEL];
               next_capture_start = wbyte[CC_START];
               next_capture_function_select = wbyte[CC_FSEL_HI:CC_FSEL_LO];
            end
            default: next_irq = next_irq;
         endcase
      end

      if (wr) begin
         next_bvalid = 1'b1;
         next_bresp = wmap ? RESP_OKAY : RESP_SLVERR;
      end
      if (rd) begin
         next_rvalid = 1'b1;
         next_rresp = rmap ? RESP_OKAY : RESP_SLVERR;
         next_rdata = rmap ? rd_byte : RESET_BYTE;
         if (rmap && ridx == IDX_TIMER_LOW) begin
            next_tsnap = tcnt;
         end
         if (rmap && ridx == IDX_EVENT_LOW) begin
            next_esnap = ecnt;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= PCEC_IDLE;
         {timer_enable, timer_prescale, timer_clock_select} <= 5'h0;
         {event_count_enable, capture_input_select, capture_start} <= 3'h0;
         capture_function_select <= FS_OFF;
         irq <= 1'b0;
         {tcnt, tsnap, thold} <= 40'h0;
         {ecnt, esnap, ehold} <= 22'h0;
         {cpu_cnt, pre} <= 9'h0;
         {sync1, sync2, samp} <= 3'h0;
         {awready, bvalid, arready, rvalid} <= 4'h0;
         {bresp, rresp} <= 4'h0;
         rdata <= RESET_BYTE;
      end else begin
         state <= next_state;
         {timer_enable, timer_prescale, timer_clock_select} <=
            {next_timer_enable, next_timer_prescale, next_timer_clock_select};
         {event_count_enable, capture_input_select, capture_start} <=
            {next_event_count_enable, next_capture_input_select, next_capture_start};
         capture_function_select <= next_capture_function_select;
         irq <= next_irq;
         {tcnt, tsnap, thold} <= {next_tcnt, next_tsnap, next_thold};
         {ecnt, esnap, ehold} <= {next_ecnt, next_esnap, next_ehold};
         {cpu_cnt, pre} <= {next_cpu_cnt, next_pre};
         sync1 <= capture_input_select ? resistor_freq_osc_i : capture_input_pin_i;
         sync2 <= sync1;
         samp <= next_samp;
         {awready, bvalid, arready, rvalid} <= {next_awready, next_bvalid, next_arready, next_rvalid};
         {bresp, rresp} <= {next_bresp, next_rresp};
         rdata <= next_rdata;
      end
   end

   assign s_axi_awready_o  = awready;
   assign s_axi_wready_o   = awready;
   assign s_axi_bvalid_o   = bvalid;
   assign s_axi_bresp_o    = bresp;
   assign s_axi_arready_o  = arready;
   assign s_axi_rvalid_o   = rvalid;
   assign s_axi_rresp_o    = rresp;
   assign s_axi_rdata_o    = {24'h0, rdata};
   assign timer_irq_flag_o = irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_stop_seen;
      state == PCEC_RUN && active && !event_count_enable && stop_edge && !wlo;
   endsequence
   sequence s_done;
      state == PCEC_IDLE && !capture_start && irq;
   endsequence

   a_stop_clears_start: assert property (s_stop_seen |=> s_done)
      else $error("stop edge did not finish capture");
   a_wait_holds_count: assert property (state == PCEC_WAIT && !wlo |=> $stable(tcnt))
      else $error("timer counted before start edge");
   a_fsel_off_idle: assert property (capture_function_select == FS_OFF
      |=> state == PCEC_IDLE)
      else $error("capture active with function select off");
   a_no_self_start: assert property (state == PCEC_IDLE && !capture_start
      |=> state == PCEC_IDLE)
      else $error("measurement began without start bit");
   a_high_waits_rise: assert property (state == PCEC_WAIT && capture_function_select == FS_HIGH
      && active && !rise |=> state == PCEC_WAIT)
      else $error("high mode left wait without rising edge");
   a_low_waits_fall: assert property (state == PCEC_WAIT && capture_function_select == FS_LOW
      && !event_count_enable && active && rise |=> state == PCEC_WAIT)
      else $error("low mode started on rising edge");
   a_event_overflow: assert property (state == PCEC_RUN && active && ovf && !wlo
      |=> ecnt == 10'h0 && state == PCEC_IDLE && irq && !capture_start)
      else $error("event overflow did not stop counting");
   a_event_load: assert property (wlo && widx == IDX_EVENT_LOW
      |=> ecnt == {$past(ehold), $past(wbyte)})
      else $error("event count not loaded from held high byte");
   a_event_snap: assert property (rd && rmap && ridx == IDX_EVENT_LOW
      |=> esnap == $past(ecnt))
      else $error("event snapshot missing");
   a_bus_answer: assert property (wr |=> bvalid ##0 s_axi_bresp_o == ($past(wmap) ?
      RESP_OKAY : RESP_SLVERR))
      else $error("write answer wrong");

endmodule // pcec_capture

// ===== verification/pcec_signal_src.sv
/*
 * Signal source model for the capture input: a square wave of set high and
 * low lengths on the selected line, a toggle every third clock on the other line.
 * Assumes its controls change only just after a rising clock edge.
 */
`timescale 1ns/1ns
module pcec_signal_src (
   input  wire logic       sys_clk_i,
   input  wire logic       run_i,
   input  wire logic       idle_level_i,
   input  wire logic       use_osc_i,
   input  wire logic [7:0] high_cycles_i,
   input  wire logic [7:0] low_cycles_i,
   output logic            capture_input_pin_o,
   output logic            resistor_freq_osc_o
);
   logic       level     = 1'b0;
   logic       next_high = 1'b0;
   logic [7:0] left      = 8'h00;
   logic [1:0] noise_cnt = 2'h0;
   logic       noise     = 1'b0;

   // ****************************************************************
   // Wave generator, every run opens with a low phase
   // ****************************************************************
   always @(posedge sys_clk_i) begin
      noise_cnt <= (noise_cnt == 2'h2) ? 2'h0 : noise_cnt + 2'h1;
      if (noise_cnt == 2'h2) begin
         noise <= ~noise;
      end
      if (!run_i) begin
         level <= idle_level_i;
         next_high <= 1'b0;
         left <= 8'h00;
      end else if (left <= 8'h01) begin
         level <= next_high;
         left <= next_high ? high_cycles_i : low_cycles_i;
         next_high <= ~next_high;
      end else begin
         left <= left - 8'h01;
      end
   end

   // Unused line keeps toggling so a wrong source select is seen
   assign capture_input_pin_o = use_osc_i ? noise : level;
   assign resistor_freq_osc_o = use_osc_i ? level : noise;

endmodule // pcec_signal_src

// ===== verification/pulse_capture_event_counter_tb.sv
/*
 * Self-checking bench for the pulse capture block: register bus, the three
 * measurement modes, prescaler, source select and event counter.
 * Assumes the signal source model as the far side of the capture input.
 */
`timescale 1ns/1ns
module pulse_capture_event_counter_tb;
   import pcec_pkg::*;
   typedef struct {string name; logic [33:0] val;} pcec_note_t;
   logic        clk, rst, awv, wv, bry, arv, rry, awr, wr_rdy, bv, arr, rv, irq;
   logic        pin, osc, run, idle, sel_osc;
   logic [3:0]  wst;
   logic [7:0]  hi_n, lo_n;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0]  br, rr;
   logic [15:0] exp_cnt;
   logic [7:0]  tm_tab [7] = '{8'h88, 8'h88, 8'h88, 8'h88, 8'h88, 8'hf0, 8'he0};
   logic [7:0]  cc_tab [7] = '{8'h05, 8'h06, 8'h07, 8'h05, 8'h0f, 8'h07, 8'h07};
   int          mismatches = 0;
   int          checked = 0;
   pcec_note_t  rq[$], wq[$], nb, nr;

   pcec_capture i_pcec_capture (.sys_clk_i(clk), .rst_i(rst), .capture_input_pin_i(pin),
      .resistor_freq_osc_i(osc), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(wst), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .timer_irq_flag_o(irq));
   pcec_signal_src i_pcec_signal_src (.sys_clk_i(clk), .run_i(run), .idle_level_i(idle),
      .use_osc_i(sel_osc), .high_cycles_i(hi_n), .low_cycles_i(lo_n),
      .capture_input_pin_o(pin), .resistor_freq_osc_o(osc));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   function automatic void check(string n, logic [33:0] e, logic [33:0] s);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endfunction

   task automatic complete_run();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   always @(posedge clk) begin
      if (bv && bry && wq.size() > 0) begin
         nb = wq.pop_front();
         check(nb.name, nb.val, {32'h0, br});
      end
      if (rv && rry && rq.size() > 0) begin
         nr = rq.pop_front();
         check(nr.name, nr.val, {rr, rdat});
      end
   end

   // ****************************************************************
   // Bus master tasks, register index times four is the byte address
   // ****************************************************************
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      int n = 0;
      @(posedge clk);
      wq.push_back(pcec_note_t'{$sformatf("bresp_%h", idx), {32'h0, r}});
      awa <= {2'b00, idx, 2'b00};
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      do begin @(posedge clk); n++; end while (!(awr && wr_rdy) && n < 100);
      awv <= 1'b0;
      wv <= 1'b0;
      do begin @(posedge clk); n++; end while (!bv && n < 300);
      bry <= 1'b0;
      if (n >= 300) check("write_timeout", 34'h0, 34'h1);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      int n = 0;
      @(posedge clk);
      rq.push_back(pcec_note_t'{$sformatf("reg_%h", idx), {r, 24'h0, d}});
      ara <= {2'b00, idx, 2'b00};
      arv <= 1'b1;
      rry <= 1'b1;
      do begin @(posedge clk); n++; end while (!arr && n < 100);
      arv <= 1'b0;
      do begin @(posedge clk); n++; end while (!rv && n < 300);
      rry <= 1'b0;
      if (n >= 300) check("read_timeout", 34'h0, 34'h1);
   endtask

   task automatic measure();
      int n = 0;
      run <= 1'b1;
      while (irq !== 1'b1 && n < 3000) begin @(posedge clk); n++; end
      run <= 1'b0;
      check("irq_flag", 34'h1, {33'h0, irq});
   endtask

   initial begin
      #(40000 * 100);
      mismatches++;
      complete_run();
   end

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      {rst, awv, wv, bry, arv, rry, run, idle, sel_osc} = 9'h100;
      {awa, ara, wd, wst, hi_n, lo_n} = {12'h0, 12'h0, 32'h0, 4'h1, 8'h4, 8'h4};
      void'($urandom(32'h9416));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rd(IDX_CAPT_CTRL, 8'h00);
      rd(IDX_EVENT_LOW, 8'h00);
      rd(IDX_EVENT_HIGH, 8'h00);
      rd(8'ha8, 8'h00, RESP_SLVERR);
      wr(8'ha8, 8'hff, RESP_SLVERR);
      wr(IDX_EVENT_HIGH, 8'h02);
      wr(IDX_EVENT_LOW, 8'h34);
      rd(IDX_EVENT_LOW, 8'h34);
      rd(IDX_EVENT_HIGH, 8'h02);
      wr(IDX_TIMER_HIGH, 8'h12);
      wr(IDX_TIMER_LOW, 8'h34);
      rd(IDX_TIMER_LOW, 8'h34);
      rd(IDX_TIMER_HIGH, 8'h12);
      wr(IDX_TIMER_HIGH, 8'h00);
      wr(IDX_TIMER_LOW, 8'h00);
      $display("test registers done");
      // Start with mode off, then mode on with the timer stopped
      wr(IDX_TIMER_MODE, 8'h88);
      wr(IDX_CAPT_CTRL, 8'h04);
      run <= 1'b1;
      repeat (60) @(posedge clk);
      wr(IDX_TIMER_MODE, 8'h08);
      wr(IDX_CAPT_CTRL, 8'h05);
      repeat (60) @(posedge clk);
      run <= 1'b0;
      rd(IDX_TIMER_LOW, 8'h00);
      rd(IDX_STATUS, 8'h00);
      wr(IDX_CAPT_CTRL, 8'h00);
      $display("test capture disabled done");
      for (int i = 0; i < 7; i++) begin
         hi_n <= (i >= 5) ? 8'h8 : 8'(3 + $urandom % 18);
         lo_n <= (i >= 5) ? 8'h8 : 8'(3 + $urandom % 18);
         idle <= (i == 3);
         sel_osc <= (i == 4);
         // Source and mode settle first, a source swap under start fakes an edge
         wr(IDX_CAPT_CTRL, cc_tab[i] & 8'hfb);
         wr(IDX_TIMER_MODE, tm_tab[i]);
         wr(IDX_TIMER_HIGH, 8'h00);
         wr(IDX_TIMER_LOW, 8'h00);
         wr(IDX_CAPT_CTRL, cc_tab[i]);
         measure();
         exp_cnt = (cc_tab[i][1:0] == FS_HIGH) ? hi_n : (cc_tab[i][1:0] == FS_LOW) ? lo_n
                   : 16'(hi_n) + 16'(lo_n);
         exp_cnt = exp_cnt / (tm_tab[i][3] ? 16'h1 : 16'h4 * (16'h80 >> tm_tab[i][6:4])) - 16'h1;
         rd(IDX_TIMER_LOW, exp_cnt[7:0]);
         rd(IDX_TIMER_HIGH, exp_cnt[15:8]);
         rd(IDX_CAPT_CTRL, cc_tab[i] & 8'hfb);
         wr(IDX_STATUS, 8'h01);
         rd(IDX_STATUS, 8'h00);
         $display("test measurement %0d done", i);
      end
      wr(IDX_TIMER_MODE, 8'h88);
      wr(IDX_TIMER_HIGH, 8'h00);
      wr(IDX_TIMER_LOW, 8'h00);
      wr(IDX_EVENT_HIGH, 8'h03);
      wr(IDX_EVENT_LOW, 8'hfd);
      {hi_n, lo_n, idle, sel_osc} <= {8'h3, 8'h4, 2'b00};
      wr(IDX_CAPT_CTRL, 8'h85);
      measure();
      repeat (40) @(posedge clk);
      rd(IDX_EVENT_LOW, 8'h00);
      rd(IDX_EVENT_HIGH, 8'h00);
      rd(IDX_TIMER_LOW, 8'h14);
      rd(IDX_TIMER_HIGH, 8'h00);
      rd(IDX_CAPT_CTRL, 8'h81);
      rd(IDX_STATUS, 8'h01);
      $display("test event counter done");
      repeat (4) @(posedge clk);
      complete_run();
   end

endmodule // pulse_capture_event_counter_tb
